// ### dv/sbs_array_model.sv
`timescale 1ns/1ps
// Behavioural storage array behind the control block, one cycle read latency.
module sbs_array_model (
	// Clock.
	input  wire logic                core_clk,
	// Array port.
	input  wire sbs_pkg::sbs_addr_t  arrayAddr,
	input  wire sbs_pkg::sbs_lanes_t arrayLaneWrite,
	input  wire logic                arrayRead,
	input  wire sbs_pkg::sbs_word_t  arrayWdata,
	output sbs_pkg::sbs_word_t       arrayRdata
);
	import sbs_pkg::*;
	sbs_word_t mem [sbs_addr_t];
	initial arrayRdata = 36'h000000000;
	always @(posedge core_clk) begin
		// A first partial write starts from a cleared word.
		if (arrayLaneWrite != 4'h0 && !mem.exists(arrayAddr)) begin
			mem[arrayAddr] = 36'h000000000;
		end
		for (int k = 0; k < 4; k++) begin
			if (arrayLaneWrite[k]) begin
				mem[arrayAddr][9*k +: 9] = arrayWdata[9*k +: 9];
			end
		end
		// Data is valid only in the cycle after a read; otherwise it toggles so late
		// sampling shows up.
		arrayRdata <= (arrayRead && mem.exists(arrayAddr)) ? mem[arrayAddr] : ~arrayRdata;
	end
endmodule

// ### dv/sbs_control_tb.sv
`timescale 1ns/1ps
module sbs_control_tb;
	import sbs_pkg::*;
	localparam sbs_addr_t A  = 19'h12345;
	localparam sbs_addr_t B  = 19'h2A0F0;
	localparam sbs_word_t D1 = 36'h5A5A5A5A5;
	localparam sbs_word_t D2 = 36'hFEDCBA987;
	localparam sbs_word_t M  = 36'h007FC01FF;
	localparam sbs_word_t MX = (D2 & M) | (D1 & ~M);
	logic       core_clk = 1'b0;
	logic       rstn = 1'b0;
	sbs_addr_t  addr = 19'h00000;
	sbs_lanes_t laneN = 4'hF;
	logic       permitN = 1'b1, fullN = 1'b1, priN = 1'b0, secN = 1'b0, hiSel = 1'b1;
	logic       procN = 1'b1, ctrlN = 1'b1, advN = 1'b1, orderN = 1'b0, snz = 1'b0;
	logic       oeN = 1'b0;
	sbs_word_t  dIn = 36'h000000000, dOut, aWdata, aRdata;
	sbs_addr_t  aAddr;
	sbs_lanes_t aWr;
	logic       dOe, aRd, pDown, snzQ;
	int         mismatches = 0, nChecks = 0;
	always #2.5 core_clk = ~core_clk;
	sbs_control i_sbs_control (.core_clk(core_clk), .rstn(rstn), .addrBit0(addr[0]),
		.addrBit1(addr[1]), .upperAddress(addr[18:2]), .laneAWriteN(laneN[0]),
		.laneBWriteN(laneN[1]), .laneCWriteN(laneN[2]), .laneDWriteN(laneN[3]),
		.laneWritePermitN(permitN), .fullWordWriteN(fullN), .primarySelectN(priN),
		.secondarySelectN(secN), .highSelect(hiSel), .procAddrStrobeN(procN),
		.ctrlAddrStrobeN(ctrlN), .burstAdvanceN(advN), .linearOrderSelN(orderN),
		.snoozeRequest(snz), .outputEnableN(oeN), .dataIn(dIn), .dataOut(dOut),
		.dataOe(dOe), .arrayAddr(aAddr), .arrayLaneWrite(aWr), .arrayRead(aRd),
		.arrayWdata(aWdata), .arrayRdata(aRdata), .powerDown(pDown), .snoozing(snzQ));
	sbs_array_model i_sbs_array_model (.core_clk(core_clk), .arrayAddr(aAddr),
		.arrayLaneWrite(aWr), .arrayRead(aRd), .arrayWdata(aWdata), .arrayRdata(aRdata));
	task automatic chk(input sbs_word_t got, input sbs_word_t exp);
		nChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask
	// One strobe cycle; controls stay put so a following strobe can take the next edge.
	task automatic issue(input logic p, input sbs_addr_t a, input logic gw, input logic pm,
		input sbs_lanes_t ln, input sbs_word_t d);
		procN = !p;
		ctrlN = p;
		addr = a;
		fullN = gw;
		permitN = pm;
		laneN = ln;
		dIn = d;
		tick();
	endtask
	// Drop strobes and write controls so the burst cycles that follow stay reads.
	task automatic quiet;
		procN = 1'b1;
		ctrlN = 1'b1;
		fullN = 1'b1;
		permitN = 1'b1;
		laneN = 4'hF;
	endtask
	task automatic readBack(input sbs_addr_t a, input sbs_word_t exp);
		issue(1'b1, a, 1'b0, 1'b0, 4'h0, 36'h000000000);
		chk(aRd, 1'b1);
		chk(aWr, 4'h0);
		chk(aAddr, a);
		quiet();
		tick();
		tick();
		chk(dOut, exp);
		chk(dOe, 1'b1);
		oeN = 1'b1;
		#1 chk(dOe, 1'b0);
		tick();
		oeN = 1'b0;
	endtask
	task automatic testDeselect;
		priN = 1'b1;
		issue(1'b1, A, 1'b1, 1'b1, 4'hF, 36'h000000000);
		chk(aRd, 1'b0);
		chk(pDown, 1'b0);
		issue(1'b0, A, 1'b0, 1'b1, 4'hF, D2);
		chk(aWr, 4'h0);
		chk(pDown, 1'b1);
		priN = 1'b0;
		issue(1'b0, A, 1'b0, 1'b1, 4'hF, D1);
		chk(aWr, 4'hF);
		chk(aWdata, D1);
		chk(pDown, 1'b0);
		secN = 1'b1;
		issue(1'b1, A, 1'b1, 1'b1, 4'hF, 36'h000000000);
		chk(aRd, 1'b0);
		chk(pDown, 1'b1);
		quiet();
		tick();
		chk(pDown, 1'b1);
		chk(aRd, 1'b0);
		secN = 1'b0;
		$display("test deselect done");
	endtask
	task automatic testWrites;
		issue(1'b0, A, 1'b1, 1'b0, 4'hA, D2);
		chk(aWr, 4'h5);
		issue(1'b0, A + 19'h1, 1'b1, 1'b1, 4'h0, D1);
		chk(aWr, 4'h0);
		chk(aRd, 1'b1);
		readBack(A, MX);
		$display("test writes done");
	endtask
	task automatic testBurst(input logic ord);
		logic [1:0] b;
		orderN = ord;
		issue(1'b1, A, 1'b1, 1'b1, 4'hF, 36'h000000000);
		quiet();
		advN = 1'b0;
		priN = 1'b1;
		hiSel = 1'b0;
		for (int k = 1; k < 6; k++) begin
			tick();
			b = ord ? (A[1:0] ^ k[1:0]) : (A[1:0] + k[1:0]);
			chk(aAddr, {A[18:2], b});
		end
		advN = 1'b1;
		tick();
		chk(aAddr, {A[18:2], b});
		chk(pDown, 1'b0);
		priN = 1'b0;
		hiSel = 1'b1;
		$display("test burst order %0d done", ord);
	endtask
	// Processor strobe starts a burst; the write follows with advance held high.
	task automatic testProcWrite;
		issue(1'b1, B, 1'b1, 1'b1, 4'hF, 36'h000000000);
		chk(aRd, 1'b1);
		procN = 1'b1;
		advN = 1'b1;
		fullN = 1'b0;
		dIn = D2;
		tick();
		chk(aWr, 4'hF);
		chk(aAddr, B);
		chk(aWdata, D2);
		readBack(B, D2);
		$display("test processor write done");
	endtask
	task automatic testSnooze;
		readBack(A, MX);
		snz = 1'b1;
		#1 chk(dOe, 1'b0);
		tick();
		issue(1'b0, A, 1'b0, 1'b1, 4'hF, D2);
		chk(aWr, 4'h0);
		chk(aRd, 1'b0);
		chk(snzQ, 1'b1);
		snz = 1'b0;
		readBack(A, MX);
		$display("test snooze done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// About forty-five cycles are needed; a thousand leaves room without hiding a hang.
	initial begin
		#5000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		#1 rstn = 1'b1;
		testDeselect();
		testWrites();
		testBurst(1'b0);
		testBurst(1'b1);
		testProcWrite();
		testSnooze();
		conclude();
	end
endmodule

// ### rtl/sbs_control.sv
`timescale 1ns/1ps
`include "sbs_defines.svh"

// Behaviour
// - Address, data, selects, lane enables and burst controls are taken each rising edge.
// - Each lane enable gates one data byte plus its parity bit.
// - Parity bits exist only in the 18- and 36-bit builds.
// - Lane writes happen only while the lane-write permit is sampled low.
// - Full-word write low writes every lane regardless of other write inputs.
// - Primary select enables the device and qualifies the processor strobe.
// - Selected only with primary low, secondary low and high select high.
// - Selects are sampled only when a new external address loads.
// - Snooze puts the device in standby while keeping array contents.
// - While snoozing every other input is ignored.
// - Snooze reads inactive when left open, thanks to a pull-down.
// - Data drivers are on only while output enable is low, asynchronously.
// - Advance low steps the burst counter after the address loads.
// - Advance high holds the burst address, giving a wait state.
// - Processor strobe aborts bursts, loads address, reads; ignored when primary high.
// - Processor strobe with high select low or secondary high powers down.
// - Controller strobe loads address and reads or writes, or powers down.
// - Order pin low gives linear, high gives interleaved burst order.
module sbs_control (
	// Clock and reset.
	input  wire logic              core_clk,
	input  wire logic              rstn,
	// Address.
	input  wire logic              addrBit0,
	input  wire logic              addrBit1,
	input  wire sbs_pkg::sbs_upper_t upperAddress,
	// Write control.
	input  wire logic              laneAWriteN,
	input  wire logic              laneBWriteN,
	input  wire logic              laneCWriteN,
	input  wire logic              laneDWriteN,
	input  wire logic              laneWritePermitN,
	input  wire logic              fullWordWriteN,
	// Selects.
	input  wire logic              primarySelectN,
	input  wire logic              secondarySelectN,
	input  wire logic              highSelect,
	// Burst control.
	input  wire logic              procAddrStrobeN,
	input  wire logic              ctrlAddrStrobeN,
	input  wire logic              burstAdvanceN,
	input  wire logic              linearOrderSelN,
	// Asynchronous controls.
	input  wire logic              snoozeRequest,
	input  wire logic              outputEnableN,
	// Data pins.
	input  wire sbs_pkg::sbs_word_t dataIn,
	output      sbs_pkg::sbs_word_t dataOut,
	output logic                   dataOe,
	// Array port.
	output      sbs_pkg::sbs_addr_t   arrayAddr,
	output      sbs_pkg::sbs_lanes_t  arrayLaneWrite,
	output logic                      arrayRead,
	output      sbs_pkg::sbs_word_t   arrayWdata,
	input  wire sbs_pkg::sbs_word_t   arrayRdata,
	// Status.
	output logic                   powerDown,
	output logic                   snoozing
);
	import sbs_pkg::*;

	sbs_state_e state;
	sbs_state_e next_state;
	sbs_addr_t  base;
	sbs_addr_t  next_base;
	logic [1:0] count;
	logic [1:0] next_count;
	sbs_addr_t  next_arrayAddr;
	sbs_lanes_t next_arrayLaneWrite;
	logic       next_arrayRead;
	sbs_word_t  next_arrayWdata;
	logic       readValid;
	logic       next_readValid;
	sbs_word_t  next_dataOut;
	logic       dataDrive;
	logic       next_dataDrive;
	logic       next_powerDown;
	logic       next_snoozing;

	logic       procTake;
	logic       ctrlTake;
	logic       selected;
	sbs_lanes_t laneReq;
	sbs_word_t  parityMask;

	// Low two address bits for a given burst step.
	function automatic logic [1:0] burstLow(input logic [1:0] start,
		input logic [1:0] step, input logic linear);
		burstLow = linear ? 2'(start + step) : (start ^ step);
	endfunction

	// Lanes written this cycle.
	function automatic sbs_lanes_t laneWrites(input logic fullN, input logic permitN,
		input sbs_lanes_t laneN);
		if (!fullN) begin
			laneWrites = `SBS_ALL_LANES;
		end else if (!permitN) begin
			laneWrites = ~laneN;
		end else begin
			laneWrites = `SBS_NO_LANES;
		end
	endfunction

	// Bits forced to zero in a build without parity.
	always_comb begin
		parityMask = '1;
		for (int k = 0; k < `SBS_LANES; k++) begin
			if (!`SBS_HAS_PARITY) begin
				parityMask[k*`SBS_LANE_W+8] = 1'b0;
			end
		end
	end

	assign procTake = !procAddrStrobeN && !primarySelectN;
	assign ctrlTake = !ctrlAddrStrobeN && !procTake;
	assign selected = !primarySelectN && !secondarySelectN && highSelect;
	assign laneReq  = laneWrites(fullWordWriteN, laneWritePermitN,
		{laneDWriteN, laneCWriteN, laneBWriteN, laneAWriteN});

	// Address and command stage. The snooze input is used unsynchronised on
	// purpose: it blocks every update at once, so no half-taken cycle occurs.
	// An open snooze pin is pulled low outside, so it reads as inactive.
	always_comb begin
		next_state          = state;
		next_base           = base;
		next_count          = count;
		next_arrayAddr      = arrayAddr;
		next_arrayLaneWrite = `SBS_NO_LANES;
		next_arrayRead      = 1'b0;
		next_arrayWdata     = dataIn & parityMask;
		next_snoozing       = snoozeRequest;
		if (snoozeRequest) begin
			next_state = SBS_IDLE;
		end else if (procTake || ctrlTake) begin
			next_base  = {upperAddress, addrBit1, addrBit0};
			next_count = `SBS_RST_COUNT;
			next_arrayAddr = {upperAddress, addrBit1, addrBit0};
			if (selected) begin
				next_state = SBS_BURST;
				if (procTake || laneReq == `SBS_NO_LANES) begin
					next_arrayRead = 1'b1;
				end else begin
					next_arrayLaneWrite = laneReq;
				end
			end else begin
				next_state = SBS_PDOWN;
			end
		end else if (state == SBS_BURST) begin
			// Selects are not looked at here.
			if (!burstAdvanceN) begin
				next_count = 2'(count + 2'h1);
			end
			next_arrayAddr = {base[`SBS_ADDR_W-1:2],
				burstLow(base[1:0], next_count, !linearOrderSelN)};
			// A write after a processor-strobe start relies on advance high.
			if (laneReq == `SBS_NO_LANES) begin
				next_arrayRead = 1'b1;
			end else begin
				next_arrayLaneWrite = laneReq;
			end
		end
		next_powerDown = (next_state == SBS_PDOWN);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state          <= SBS_IDLE;
			base           <= `SBS_RST_ADDR;
			count          <= `SBS_RST_COUNT;
			arrayAddr      <= `SBS_RST_ADDR;
			arrayLaneWrite <= `SBS_NO_LANES;
			arrayRead      <= 1'b0;
			arrayWdata     <= `SBS_RST_WORD;
			powerDown      <= 1'b0;
			snoozing       <= 1'b0;
		end else begin
			state          <= next_state;
			base           <= next_base;
			count          <= next_count;
			arrayAddr      <= next_arrayAddr;
			arrayLaneWrite <= next_arrayLaneWrite;
			arrayRead      <= next_arrayRead;
			arrayWdata     <= next_arrayWdata;
			powerDown      <= next_powerDown;
			snoozing       <= next_snoozing;
		end
	end

	// Output pipeline: the array answers one cycle after a read strobe.
	always_comb begin
		next_readValid = arrayRead;
		next_dataOut   = dataOut;
		next_dataDrive = readValid;
		if (readValid) begin
			next_dataOut = arrayRdata & parityMask;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			readValid <= 1'b0;
			dataOut   <= `SBS_RST_WORD;
			dataDrive <= 1'b0;
		end else begin
			readValid <= next_readValid;
			dataOut   <= next_dataOut;
			dataDrive <= next_dataDrive;
		end
	end

	// Output enable gates the drivers without waiting for a clock edge, so
	// this one output is combinational by design.
	assign dataOe = dataDrive && !outputEnableN && !snoozeRequest;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	logic quietBurst;
	assign quietBurst = !snoozeRequest && state == SBS_BURST
		&& procAddrStrobeN && ctrlAddrStrobeN;

	a_snooze_blocks: assert property (snoozeRequest |=>
		arrayLaneWrite == `SBS_NO_LANES && !arrayRead && snoozing)
		else $error("Array accessed while snoozing.");
	a_full_word: assert property (quietBurst && !fullWordWriteN |=>
		arrayLaneWrite == `SBS_ALL_LANES)
		else $error("Full-word write missed a lane.");
	a_permit_gate: assert property (quietBurst && fullWordWriteN
		&& laneWritePermitN |=> arrayLaneWrite == `SBS_NO_LANES && arrayRead)
		else $error("Lane written without permit.");
	a_proc_read: assert property (!snoozeRequest && procTake && selected
		|=> arrayRead && arrayLaneWrite == `SBS_NO_LANES ##2 dataDrive)
		else $error("Processor strobe did not read.");
	a_proc_ignored: assert property (!snoozeRequest && !procAddrStrobeN
		&& primarySelectN && ctrlAddrStrobeN && state == SBS_IDLE
		|=> !arrayRead && arrayLaneWrite == `SBS_NO_LANES)
		else $error("Strobe acted on with primary select high.");
	a_deselect_pd: assert property (!snoozeRequest && (procTake || ctrlTake)
		&& !selected |=> powerDown && state == SBS_PDOWN)
		else $error("Deselect did not power down.");
	a_wait_hold: assert property (quietBurst && burstAdvanceN
		|=> arrayAddr == $past(arrayAddr))
		else $error("Address moved in a wait state.");
	a_burst_step: assert property (quietBurst && !burstAdvanceN
		|=> arrayAddr[1:0] != $past(arrayAddr[1:0])
		&& arrayAddr[`SBS_ADDR_W-1:2] == $past(arrayAddr[`SBS_ADDR_W-1:2]))
		else $error("Burst did not step within its block.");
	a_selects_ignored: assert property (quietBurst |=> !powerDown)
		else $error("Select sampled during a burst.");
	a_oe_gate: assert property (dataOe |-> !outputEnableN && $past(arrayRead, 2))
		else $error("Drivers on without a read two cycles back.");

	// Address loading and burst counting.
	a_load_addr: assert property (!snoozeRequest && (procTake || ctrlTake)
		|=> arrayAddr == $past({upperAddress, addrBit1, addrBit0}))
		else $error("Strobe did not load the external address.");
	a_count_clear: assert property (!snoozeRequest && (procTake || ctrlTake)
		|=> count == `SBS_RST_COUNT) else $error("Burst counter not cleared on load.");
	a_burst_wrap: assert property (quietBurst && !burstAdvanceN && count == 2'h3
		|=> count == 2'h0) else $error("Burst counter did not wrap.");
	a_linear_step: assert property (quietBurst && !burstAdvanceN && !linearOrderSelN
		|=> arrayAddr[1:0] == 2'($past(arrayAddr[1:0]) + 2'h1))
		else $error("Linear burst skipped a word.");

	// Write lanes and data. A lane strobe must never come with a read strobe,
	// or the array would see both directions in one cycle.
	a_lane_select: assert property (!snoozeRequest && fullWordWriteN
		&& !laneWritePermitN && ((ctrlTake && selected) || quietBurst)
		|=> arrayLaneWrite == ~$past({laneDWriteN, laneCWriteN, laneBWriteN, laneAWriteN}))
		else $error("Lane strobes do not follow the lane enables.");
	a_write_data: assert property (arrayLaneWrite != `SBS_NO_LANES
		|-> arrayWdata == ($past(dataIn) & parityMask))
		else $error("Written word differs from the data pins.");
	a_rw_exclusive: assert property (!(arrayRead && arrayLaneWrite != `SBS_NO_LANES))
		else $error("Read and write strobes together.");
	a_ctrl_write: assert property (!snoozeRequest && ctrlTake && selected
		&& laneReq != `SBS_NO_LANES |=> arrayLaneWrite == $past(laneReq) && !arrayRead)
		else $error("Controller strobe write not carried out.");

	// Power-down and snooze.
	a_ctrl_deselect: assert property (!snoozeRequest && ctrlTake && primarySelectN
		|=> powerDown && !arrayRead && arrayLaneWrite == `SBS_NO_LANES)
		else $error("Controller strobe with primary select high did not power down.");
	a_pdown_quiet: assert property (!snoozeRequest && state == SBS_PDOWN
		&& procAddrStrobeN && ctrlAddrStrobeN
		|=> powerDown && !arrayRead && arrayLaneWrite == `SBS_NO_LANES)
		else $error("Array touched in power-down.");
	a_snooze_idle: assert property (snoozeRequest |=> state == SBS_IDLE && !powerDown)
		else $error("Snooze did not park the control logic.");
	a_snooze_drive: assert property (snoozeRequest |-> !dataOe)
		else $error("Data drivers on while snoozing.");

	c_proc_read: cover property (procTake && selected ##1 arrayRead ##2 dataOe);
	c_ctrl_write: cover property (ctrlTake && selected && laneReq != `SBS_NO_LANES);
	c_wait_state: cover property (quietBurst && burstAdvanceN);
	c_snooze: cover property (snoozeRequest ##1 snoozing);
	c_proc_write: cover property (procTake && selected ##1 quietBurst && burstAdvanceN
		&& laneReq != `SBS_NO_LANES);

endmodule

// ### rtl/sbs_defines.svh
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

// Word layout: four lanes of nine bits, parity on bit 8 of each lane.
`define SBS_LANES      4
`define SBS_LANE_W     9
`define SBS_WORD_W     36
`define SBS_UPPER_W    17
`define SBS_ADDR_W     19
`define SBS_HAS_PARITY 1'b1

// Reset values and lane masks.
`define SBS_RST_ADDR   19'h00000
`define SBS_RST_WORD   36'h000000000
`define SBS_RST_COUNT  2'h0
`define SBS_NO_LANES   4'h0
`define SBS_ALL_LANES  4'hF

`endif

// ### rtl/sbs_pkg.sv
`include "sbs_defines.svh"

package sbs_pkg;

	typedef enum logic [1:0] {
		SBS_IDLE  = 2'b00,
		SBS_BURST = 2'b01,
		SBS_PDOWN = 2'b11
	} sbs_state_e;

	typedef logic [`SBS_WORD_W-1:0]  sbs_word_t;
	typedef logic [`SBS_ADDR_W-1:0]  sbs_addr_t;
	typedef logic [`SBS_UPPER_W-1:0] sbs_upper_t;
	typedef logic [`SBS_LANES-1:0]   sbs_lanes_t;

endpackage
